// [rtl/epr_pkg.sv]
// Purpose: shared constants for the packet record extractor
// Assumes: 10 MHz core clock, APB register access
// Notes:   offsets are byte addresses of 32-bit registers
package epr_pkg;
  localparam logic [7:0]  REG_FILTER_CTRL  = 8'h00;
  localparam logic [7:0]  REG_DATA_OFFSET  = 8'h04;
  localparam logic [7:0]  REG_FILL_PATTERN = 8'h08;
  localparam logic [7:0]  REG_SRC_MAC_LO   = 8'h0C;
  localparam logic [7:0]  REG_SRC_MAC_HI   = 8'h10;
  localparam logic [7:0]  REG_CHECK_ERRORS = 8'h14;
  localparam logic [7:0]  REG_STATUS       = 8'h18;
  localparam logic [7:0]  REG_DROP_COUNT   = 8'h1C;
  localparam logic [7:0]  REG_RECORD_CTRL  = 8'h20;
  localparam int          CTRL_RAW_BIT     = 0;
  localparam int          CTRL_SRCFILT_BIT = 1;
  localparam int          CTRL_CHKDIS_BIT  = 2;
  localparam int          CTRL_PROMISC_BIT = 4;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0010;
  localparam logic [31:0] FILL_RESET       = 32'h0000_0000;
  localparam logic [15:0] OFFSET_RESET     = 16'h0000;
  localparam int          PREAMBLE_BYTES   = 8;
  localparam int          HEADER_BYTES     = 14;
  localparam int          SRC_MAC_FIRST    = 6;
  localparam int          FCS_BYTES        = 4;
  localparam int          JUMBO_BYTES      = 9000;
  localparam int          BUF_PACKETS      = 5;
  localparam int          BUF_WORDS        = (JUMBO_BYTES * BUF_PACKETS) / 8;
endpackage

// [rtl/epr_record_extractor.sv]
// Purpose: extract recorded words from received Ethernet packets
// Assumes: byte-wide receive stream with start, end and check-error flags
// Notes:   whole packets are staged, then released or dropped at their end
//
// Overview of operation
// - each received packet is one data frame to record
// - record bytes from data offset to packet end, check value excluded; outside raw mode a last partial word is dropped
// - offset counts from first byte after MAC client header
// - jumbo packets up to 9000 bytes are accepted and recorded
// - offset sixteen skips data frame header, recording only payload
// - preamble only locks onto packet and is never recorded
// - raw mode records every byte but preamble, offset ignored
// - raw mode pads last word with fill pattern to eight bytes
// - source filtering keeps only packets from programmed MAC address
// - input buffer holds five jumbo packets, about 45000 bytes
// - control bit zero enables raw mode, overriding other modes
// - check errors drop packet unless bit two set; always counted
// - control bit four promiscuous, set at reset, skips address compare
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
module epr_record_extractor
  import epr_pkg::*;
#(
  parameter int DEPTH = BUF_WORDS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // receive byte stream, preamble included
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxStart,
  input  wire logic        rxEnd,
  input  wire logic        rxCheckErr,
  // recorded words
  output      logic        recValid,
  input  wire logic        recReady,
  output      logic [63:0] recData
);
  localparam int AW = $clog2(DEPTH + 1);

  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_BODY, ST_PAD} epr_rx_t;

  // registers
  logic [31:0] ctrl_q;
  logic [15:0] offset_q;
  logic [31:0] fill_q;
  logic [47:0] mac_q;
  logic [31:0] chkErr_q;
  logic [31:0] drops_q;
  logic        recEn_q;

  // receive state
  epr_rx_t     st_q;
  logic [13:0] pos_q;
  logic [2:0]  lane_q;
  logic [63:0] asm_q;
  logic [47:0] srcMac_q;
  logic [31:0] tail_q;
  logic [2:0]  tailN_q;
  logic        over_q;

  // staging memory: words committed only at packet end
  logic [63:0]   mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] wrStart_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0]   used_q;
  logic [AW:0]   pend_q;

  logic          rawMode;
  logic          wordPush;
  logic [63:0]   wordData;
  logic          pktEnd;
  logic          keepPkt;
  logic          apbWr;
  logic [31:0]   rdMux;

  epr_skid_if #(.W(64)) skid ();

  function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
    ptrInc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  function automatic logic [63:0] putByte(input logic [63:0] w, input logic [2:0] l, input logic [7:0] b);
    logic [63:0] r;
    r = w;
    r[l*8 +: 8] = b;
    putByte = r;
  endfunction

  assign rawMode = ctrl_q[CTRL_RAW_BIT];

  // apb: zero wait states, unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign apbWr   = psel && penable && pwrite;
  always_comb
  begin
    rdMux   = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      REG_FILTER_CTRL:  rdMux = ctrl_q;
      REG_DATA_OFFSET:  rdMux = {16'h0000, offset_q};
      REG_FILL_PATTERN: rdMux = fill_q;
      REG_SRC_MAC_LO:   rdMux = mac_q[31:0];
      REG_SRC_MAC_HI:   rdMux = {16'h0000, mac_q[47:32]};
      REG_CHECK_ERRORS: rdMux = chkErr_q;
      REG_STATUS:       rdMux = {{(31 - AW){1'b0}}, used_q};
      REG_DROP_COUNT:   rdMux = drops_q;
      REG_RECORD_CTRL:  rdMux = {31'h0000_0000, recEn_q};
      default:          pslverr = psel && penable;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rdMux;
  end

  // offset is expected stable while recording; it is read live on every byte, not sampled per packet
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q   <= CTRL_RESET;
      offset_q <= OFFSET_RESET;
      fill_q   <= FILL_RESET;
      mac_q    <= '0;
      recEn_q  <= 1'b0;
    end
    else if (apbWr)
    begin
      unique case (paddr)
        REG_FILTER_CTRL:  ctrl_q <= pwdata;
        REG_DATA_OFFSET:  offset_q <= pwdata[15:0];
        REG_FILL_PATTERN: fill_q <= pwdata;
        REG_SRC_MAC_LO:   mac_q[31:0] <= pwdata;
        REG_SRC_MAC_HI:   mac_q[47:32] <= pwdata[15:0];
        REG_RECORD_CTRL:  recEn_q <= pwdata[0];
        default:          ;
      endcase
    end
  end

  // check errors are counted whatever the disable bit says; counting wins over clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      chkErr_q <= '0;
    else if (pktEnd && rxCheckErr)
      chkErr_q <= chkErr_q + 32'd1;
    else if (apbWr && paddr == REG_CHECK_ERRORS && pwdata == 32'h0000_0000)
      chkErr_q <= '0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      drops_q <= '0;
    else if (pktEnd && !keepPkt)
      drops_q <= drops_q + 32'd1;
    else if (apbWr && paddr == REG_DROP_COUNT)
      drops_q <= '0;
  end

  // packet framing: preamble bytes are consumed and never placed in a word
  assign pktEnd = (st_q == ST_BODY) && rxValid && rxEnd;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= ST_IDLE;
      pos_q <= '0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
          if (rxValid && rxStart && recEn_q)
          begin
            st_q  <= ST_PRE;
            pos_q <= 14'd1;
          end
        ST_PRE:
          if (rxValid)
          begin
            pos_q <= pos_q + 14'd1;
            if (pos_q == 14'(PREAMBLE_BYTES - 1))
            begin
              st_q  <= ST_BODY;
              pos_q <= '0;
            end
          end
        ST_BODY:
          if (rxValid)
          begin
            if (pos_q != 14'h3FFF)
              pos_q <= pos_q + 14'd1;
            if (rxEnd)
              st_q <= (rawMode && lane_q != 3'd7) ? ST_PAD : ST_IDLE;
          end
        ST_PAD:
          if (lane_q == 3'd7)
            st_q <= ST_IDLE;
      endcase
    end
  end

  // body bytes trail by four so the check value is never taken outside raw mode
  logic inSpan;
  logic [13:0] bodyIdx;
  assign bodyIdx = pos_q - 14'(FCS_BYTES);
  assign inSpan  = (st_q == ST_BODY) && rxValid && (rawMode || (pos_q >= 14'(FCS_BYTES) &&
                   bodyIdx >= 14'(HEADER_BYTES) + offset_q[13:0]));

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tail_q   <= '0;
      srcMac_q <= '0;
    end
    else if (st_q == ST_BODY && rxValid)
    begin
      tail_q <= {rxByte, tail_q[31:8]};
      if (pos_q >= 14'(SRC_MAC_FIRST) && pos_q < 14'(SRC_MAC_FIRST + 6))
        srcMac_q <= {srcMac_q[39:0], rxByte};
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lane_q <= '0;
      asm_q  <= '0;
    end
    else if (st_q == ST_IDLE)
      lane_q <= '0;
    else if (inSpan)
    begin
      asm_q  <= putByte(asm_q, lane_q, rawMode ? rxByte : tail_q[7:0]);
      lane_q <= lane_q + 3'd1;
    end
    else if (st_q == ST_PAD)
    begin
      asm_q  <= putByte(asm_q, lane_q, fill_q[lane_q[1:0]*8 +: 8]);
      lane_q <= lane_q + 3'd1;
    end
  end

  assign wordPush = (inSpan || st_q == ST_PAD) && lane_q == 3'd7;
  assign wordData = putByte(asm_q, 3'd7, (st_q == ST_PAD) ? fill_q[31:24] : rawMode ? rxByte : tail_q[7:0]);

  // decide at packet end whether the staged words are released
  logic        filtOk;
  logic        bufFull;
  logic        popWord;
  logic        commit;
  logic [AW:0] commitN;
  logic        keep_q;
  assign filtOk  = rawMode || ctrl_q[CTRL_PROMISC_BIT] || !ctrl_q[CTRL_SRCFILT_BIT] ||
                   srcMac_q == mac_q;
  assign keepPkt = filtOk && !over_q && !(wordPush && bufFull) &&
                   (rawMode || ctrl_q[CTRL_CHKDIS_BIT] || !rxCheckErr);
  // staging buffer sized for five jumbo packets
  assign bufFull = (used_q + pend_q) >= (AW + 1)'(DEPTH);
  assign popWord = (used_q != '0) && skid.ready;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_q   <= '0;
      wrStart_q <= '0;
      pend_q    <= '0;
      over_q    <= 1'b0;
    end
    else
    begin
      if (st_q == ST_IDLE)
      begin
        over_q <= 1'b0;
        pend_q <= '0;
        wrPtr_q <= wrStart_q;
      end
      else if (wordPush)
      begin
        if (bufFull)
          over_q <= 1'b1;
        else
        begin
          wrPtr_q <= ptrInc(wrPtr_q);
          pend_q  <= pend_q + (AW + 1)'(1);
        end
      end
      if (commit)
        wrStart_q <= (wordPush && !bufFull) ? ptrInc(wrPtr_q) : wrPtr_q;
    end
  end

  // words are released in arrival order
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      keep_q <= 1'b0;
    else if (pktEnd)
      keep_q <= keepPkt;
  end
  assign commit  = (pktEnd && keepPkt && !(rawMode && lane_q != 3'd7)) ||
                   (st_q == ST_PAD && lane_q == 3'd7 && keep_q && !over_q && !(wordPush && bufFull));
  assign commitN = pend_q + ((wordPush && !bufFull) ? (AW + 1)'(1) : '0);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      used_q  <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      used_q <= used_q + (commit ? commitN : '0) - (popWord ? (AW + 1)'(1) : '0);
      if (popWord)
        rdPtr_q <= ptrInc(rdPtr_q);
    end
  end

  always_ff @(posedge clk)
  begin
    if (wordPush && !bufFull)
      mem_q[wrPtr_q] <= wordData;
  end

  assign skid.valid = (used_q != '0);
  assign skid.data  = mem_q[rdPtr_q];

  epr_skid_buf #(.W(64)) u_skid (
    .clk      (clk),
    .resetn   (resetn),
    .inp      (skid),
    .outValid (recValid),
    .outReady (recReady),
    .outData  (recData)
  );
endmodule

// [rtl/epr_skid_buf.sv]
// Purpose: two-entry buffer on the record output path
// Assumes: synchronous inputs, resetn asynchronous active low
// Notes:   ready is high while fewer than two words are held
`timescale 1ns/1ps
module epr_skid_buf #(
  parameter int W = 64
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // fill side
  epr_skid_if.snk           inp,
  // drain side
  output      logic         outValid,
  input  wire logic         outReady,
  output      logic [W-1:0] outData
);
  logic [W-1:0] mem_q [2];
  logic         rdPtr_q;
  logic         wrPtr_q;
  logic [1:0]   count_q;
  logic         push;
  logic         pop;

  assign inp.ready = (count_q != 2'd2);
  assign push      = inp.valid && inp.ready;
  assign pop       = outValid && outReady;
  assign outValid  = (count_q != 2'd0);
  assign outData   = mem_q[rdPtr_q];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_q <= 2'd0;
      rdPtr_q <= 1'b0;
      wrPtr_q <= 1'b0;
    end
    else
    begin
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
      if (push)
        wrPtr_q <= ~wrPtr_q;
      if (pop)
        rdPtr_q <= ~rdPtr_q;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else if (push)
      mem_q[wrPtr_q] <= inp.data;
  end
endmodule

// [rtl/epr_skid_if.sv]
// Purpose: valid/ready word carrier between extractor and skid buffer
// Assumes: single clock
// Notes:   one 64-bit word per handshake
`timescale 1ns/1ps
interface epr_skid_if #(parameter int W = 64);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [test/epr_record_extractor_chk.sv]
// Purpose: port assertions for the packet record extractor
// Assumes: zero-wait apb slave, one clock
// Notes:   bound to the top module
`timescale 1ns/1ps
module epr_record_extractor_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // record words
  input wire logic        recValid,
  input wire logic        recReady,
  input wire logic [63:0] recData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic acc;
  assign acc = psel && penable;

  a_ready_zero_wait:
    assert property (psel && !penable |=> pready) else $error("pready low in access");
  a_err_unmapped:
    assert property (acc && paddr > 8'h20 |-> pslverr) else $error("no error on unmapped");
  a_ok_mapped:
    assert property (acc && paddr <= 8'h20 && paddr[1:0] == 2'd0 |-> !pslverr) else $error("error on mapped");
  a_err_only_access:
    assert property (pslverr |-> acc) else $error("error outside access");
  a_rdata_held:
    assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
  a_valid_held:
    assert property (recValid && !recReady |=> recValid) else $error("word lost under stall");
  a_data_held:
    assert property (recValid && !recReady |=> $stable(recData)) else $error("word changed under stall");
  a_quiet_reset:
    assert property ($rose(resetn) |-> !recValid [*8]) else $error("word without packet");
endmodule

bind epr_record_extractor epr_record_extractor_chk chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .recValid, .recReady, .recData);

// [test/epr_src_model.sv]
// Purpose: data source model sending ethernet packets byte by byte
// Assumes: one byte per clock, preamble added here
// Notes:   idle gap after each packet keeps the rate below capacity
`timescale 1ns/1ps
module epr_src_model (
  // clock
  input  wire logic       clk,
  // byte stream
  output      logic       rxValid,
  output      logic [7:0] rxByte,
  output      logic       rxStart,
  output      logic       rxEnd,
  output      logic       rxCheckErr
);
  initial {rxValid, rxStart, rxEnd, rxCheckErr, rxByte} = '0;

  // one frame per packet; pk holds header, client data and check bytes
  task automatic send(input logic [7:0] pk[$], input logic bad);
    int n;
    n = 8 + pk.size();
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      rxValid    <= 1'b1;
      rxStart    <= (i == 0);
      rxByte     <= (i < 7) ? 8'h55 : (i == 7) ? 8'hD5 : pk[i-8];
      rxEnd      <= (i == n - 1);
      rxCheckErr <= bad && (i == n - 1);
    end
    @(posedge clk);
    rxValid    <= 1'b0;
    rxStart    <= 1'b0;
    rxEnd      <= 1'b0;
    rxCheckErr <= 1'b0;
    rxByte     <= ~rxByte;
    repeat (12) @(posedge clk);
  endtask
endmodule

// [test/ethernet_packet_record_extractor_tb.sv]
// Purpose: self-checking bench for the packet record extractor
// Assumes: zero-wait apb, source model drives the byte stream
// Notes:   buffer depth shrunk to one jumbo packet
`timescale 1ns/1ps
module ethernet_packet_record_extractor_tb;
  import epr_pkg::*;
  localparam logic [47:0] MAC_A = 48'h0A1B_2C3D_4E5F;
  localparam logic [47:0] MAC_B = 48'h0A1B_2C3D_4E60;
  logic        clk = 0;
  logic        resetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, recValid;
  logic        recReady = 0;
  logic [63:0] recData;
  logic        rxValid, rxStart, rxEnd, rxCheckErr;
  logic [7:0]  rxByte;
  logic [1:0]  cyc = 0;
  int          stall = 1;
  int          seq = 0;
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [63:0] exp[$];
  logic [7:0]  pk[$];

  always #50 clk = ~clk;

  epr_record_extractor #(.DEPTH(1125)) dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rxValid, .rxByte, .rxStart, .rxEnd, .rxCheckErr, .recValid, .recReady,
    .recData);
  epr_src_model src (.clk, .rxValid, .rxByte, .rxStart, .rxEnd, .rxCheckErr);

  task automatic results();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    samples_checked++;
    if (got !== want)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // sequence-numbered data, same structure each packet
  task automatic mk(input logic [47:0] mac, input int nd);
    pk = {};
    repeat (6) pk.push_back(8'h02);
    for (int i = 5; i >= 0; i--)
      pk.push_back(mac[8*i+:8]);
    pk.push_back(8'h08);
    pk.push_back(8'h00);
    for (int i = 0; i < nd; i++)
      pk.push_back(8'(i * 7 + seq));
    seq++;
    repeat (4) pk.push_back(8'hC9);
  endtask

  task automatic want(input int s, input int e, input logic [31:0] fill);
    logic [63:0] w;
    for (int p = s; p < e || (p - s) % 8 != 0; p++)
    begin
      w[8*((p-s)%8)+:8] = (p < e) ? pk[p] : fill[8*((p-s)%4)+:8];
      if ((p - s) % 8 == 7)
        exp.push_back(w);
    end
  endtask

  task automatic go(input logic bad, input logic snd = 1'b1);
    if (snd)
      src.send(pk, bad);
    for (int i = 0; i < 3000 && exp.size() != 0; i++)
      @(posedge clk);
    repeat (20) @(posedge clk);
    chk(64'(exp.size()), 64'h0);
  endtask

  always @(posedge clk)
  begin
    cyc      <= cyc + 2'd1;
    recReady <= (stall == 0) || (stall == 1 && cyc[1]);
    if (recValid === 1'b1 && recReady === 1'b1)
    begin
      if (exp.size() != 0)
        chk(recData, exp.pop_front());
      else
      begin
        n_fail++;
        $display("mismatch at %0t: extra word %h", $time, recData);
      end
    end
  end

  initial
  begin
    #4_000_000;
    n_fail++;
    results();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    apb(0, REG_FILTER_CTRL, 0);
    chk(64'(rd), 64'(CTRL_RESET));
    apb(0, 8'h40, 0);
    chk(64'(err), 64'h1);
    apb(1, REG_RECORD_CTRL, 1);
    mk(MAC_B, 16);
    want(14, 30, 0);
    go(0);
    apb(1, REG_DATA_OFFSET, 16);
    mk(MAC_B, 40);
    want(30, 54, 0);
    go(0);
    go(1);
    apb(1, REG_FILTER_CTRL, 32'h14);
    want(30, 54, 0);
    go(1);
    apb(0, REG_CHECK_ERRORS, 0);
    chk(64'(rd), 64'h2);
    apb(1, REG_SRC_MAC_LO, MAC_A[31:0]);
    apb(1, REG_SRC_MAC_HI, {16'h0, MAC_A[47:32]});
    apb(1, REG_FILTER_CTRL, 32'h2);
    go(0);
    mk(MAC_A, 40);
    want(30, 54, 0);
    go(0);
    apb(1, REG_FILTER_CTRL, 32'h12);
    mk(MAC_B, 40);
    want(30, 54, 0);
    go(0);
    apb(1, REG_FILL_PATTERN, 32'hDEAD_BEEF);
    apb(1, REG_FILTER_CTRL, 32'h3);
    mk(MAC_B, 3);
    want(0, 21, 32'hDEAD_BEEF);
    go(0);
    apb(1, REG_FILTER_CTRL, 32'h10);
    stall <= 2;
    mk(MAC_B, 8976);
    want(30, 8990, 0);
    src.send(pk, 0);
    mk(MAC_B, 144);
    src.send(pk, 0);
    stall <= 1;
    go(0, 0);
    apb(0, REG_DROP_COUNT, 0);
    chk(64'(rd), 64'h3);
    results();
  end
endmodule
